// *** wdog_map.svh ***
// register offsets, field positions, reset values and timing counts of the watchdog
`ifndef WDOG_MAP_SVH
`define WDOG_MAP_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define OFS_SVC 4'h0
`define OFS_CTRL 4'h4
`define OFS_STAT 4'h8

// ************************************************************
// service register fields
// ************************************************************
`define SVC_SEL_HI 7
`define SVC_SEL_LO 6
`define SVC_KEY_HI 5
`define SVC_KEY_LO 1
`define SVC_CM_BIT 0
`define SVC_KEY 5'h0c
`define SVC_SEL_RST 2'h3
`define SVC_CM_RST 1'h1

// ************************************************************
// control and status fields
// ************************************************************
`define CTRL_HALT_BIT 0
`define CTRL_IDLE_BIT 1
`define CTRL_DLY_BIT 2
`define CTRL_RC_BIT 3
`define CTRL_RST 4'h0
`define STAT_IDLE_FLAG_BIT 0
`define STAT_WD_ERR_BIT 1
`define STAT_CM_ERR_BIT 2
`define STAT_CFG_BIT 3
`define STAT_PIN_BIT 4
`define STAT_HALT_BIT 5
`define STAT_IDLE_BIT 6

// ************************************************************
// timing
// ************************************************************
`define TC_DIV 4'ha
`define LOWER_TC 17'h00800
`define UPPER_BASE_TC 17'h02000
`define HOLD_TC 5'h11
`define IDLE_FLAG_BIT 12
`define CORE_MHZ 50
`define CM_LIMIT_US 1000

`endif

// *** wdog_pkg.sv ***
// types shared by the watchdog and clock monitor
package wdog_pkg;

	// ************************************************************
	// fault pin sequencer states
	// ************************************************************
	typedef enum logic [1:0] {
		F_IDLE,
		F_DRIVE,
		F_HOLD,
		F_WAIT_HIGH
	} fault_state_t;

	// ************************************************************
	// service byte layout
	// ************************************************************
	typedef struct packed {
		logic [1:0] sel;
		logic [4:0] key;
		logic cm_en;
	} svc_fields_t;

endpackage : wdog_pkg

// *** windowed_watchdog_clock_monitor.sv ***
// windowed watchdog and clock monitor with avalon-mm register slave
`timescale 1ns/1ns
`include "wdog_map.svh"
// ************************************************************
// ************************************************************

module windowed_watchdog_clock_monitor #(
	parameter int CM_LIMIT_CYC = `CM_LIMIT_US * `CORE_MHZ
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic oscillator_input_pin,
	input wire logic fault_out_n_i,
	output logic fault_out_n_o,
	output logic fault_out_n_oe
);

	// ************************************************************
	// declarations
	// ************************************************************
	logic wait_ff;
	logic [31:0] rdata_ff;
	logic commit_wr;
	logic wr_svc;
	logic wr_ctrl;
	logic wr_stat;
	logic [3:0] ctrl_ff;
	logic halt_mode;
	logic idle_mode;
	logic halt_d_ff;
	logic idle_d_ff;
	logic halt_exit;
	logic idle_exit;
	logic osc_d_ff;
	logic osc_rise;
	logic [3:0] div_ff;
	logic tc_en;
	wdog_pkg::svc_fields_t cfg_ff;
	wdog_pkg::svc_fields_t wr_fields;
	logic configured_ff;
	logic [16:0] wd_cnt_ff;
	logic [16:0] upper_tc;
	logic svc_ok;
	logic svc_bad;
	logic wd_timeout;
	logic wd_trig;
	logic win_restart;
	logic wd_err_ff;
	logic [19:0] cm_cnt_ff;
	logic cm_slow_ff;
	logic cm_active;
	wdog_pkg::fault_state_t fstate_ff;
	wdog_pkg::fault_state_t nxt_fstate;
	logic [4:0] hold_ff;
	logic [15:0] idle_cnt_ff = 16'h0000;
	logic idle_bit_d_ff = 1'b0;
	logic idle_flag_ff;
	logic idle_flag_set;
	logic idle_flag_clr;

	function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
		hit = (addr == ofs);
	endfunction : hit

	// ************************************************************
	// avalon-mm slave: one wait cycle, commit on waitrequest low
	// ************************************************************
	assign commit_wr = write & ~wait_ff;
	assign wr_svc = commit_wr & hit(address, `OFS_SVC) & byteenable[0];
	assign wr_ctrl = commit_wr & hit(address, `OFS_CTRL) & byteenable[0];
	assign wr_stat = commit_wr & hit(address, `OFS_STAT) & byteenable[0];

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			wait_ff <= 1'b1;
		else if ((read | write) & wait_ff)
			wait_ff <= 1'b0;
		else
			wait_ff <= 1'b1;
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			rdata_ff <= 32'h00000000;
		else if (read & wait_ff)
		begin
			rdata_ff <= 32'h00000000;
			if (hit(address, `OFS_SVC))
				rdata_ff[7:0] <= {cfg_ff.sel, 5'h00, cfg_ff.cm_en};
			else if (hit(address, `OFS_CTRL))
				rdata_ff[3:0] <= ctrl_ff;
			else if (hit(address, `OFS_STAT))
			begin
				rdata_ff[`STAT_IDLE_FLAG_BIT] <= idle_flag_ff;
				rdata_ff[`STAT_WD_ERR_BIT] <= wd_err_ff;
				rdata_ff[`STAT_CM_ERR_BIT] <= cm_slow_ff;
				rdata_ff[`STAT_CFG_BIT] <= configured_ff;
				rdata_ff[`STAT_PIN_BIT] <= fault_out_n_i;
				rdata_ff[`STAT_HALT_BIT] <= halt_mode;
				rdata_ff[`STAT_IDLE_BIT] <= idle_mode;
			end
		end
	end

	assign readdata = rdata_ff;
	assign waitrequest = wait_ff;

	// ************************************************************
	// control register: low-power modes and oscillator options
	// ************************************************************
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			ctrl_ff <= `CTRL_RST;
		else if (wr_ctrl)
			ctrl_ff <= writedata[3:0];
	end

	assign halt_mode = ctrl_ff[`CTRL_HALT_BIT];
	assign idle_mode = ctrl_ff[`CTRL_IDLE_BIT];

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			halt_d_ff <= 1'b0;
			idle_d_ff <= 1'b0;
		end
		else
		begin
			halt_d_ff <= halt_mode;
			idle_d_ff <= idle_mode;
		end
	end

	assign halt_exit = halt_d_ff & ~halt_mode;
	assign idle_exit = idle_d_ff & ~idle_mode;

	// ************************************************************
	// instruction cycle enable: oscillator edges divided by ten
	// ************************************************************
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			osc_d_ff <= 1'b0;
		else
			osc_d_ff <= oscillator_input_pin;
	end

	// halt stops the oscillator path
	assign osc_rise = oscillator_input_pin & ~osc_d_ff & ~halt_mode;

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			div_ff <= 4'h0;
		else if (osc_rise)
			div_ff <= (div_ff == `TC_DIV - 4'h1) ? 4'h0 : div_ff + 4'h1;
	end

	assign tc_en = osc_rise & (div_ff == `TC_DIV - 4'h1);

	// ************************************************************
	// service decode
	// ************************************************************
	assign wr_fields = writedata[7:0];
	assign upper_tc = `UPPER_BASE_TC << cfg_ff.sel;

	always_comb
	begin
		svc_ok = 1'b0;
		svc_bad = 1'b0;
		if (wr_svc && fstate_ff == wdog_pkg::F_IDLE)
		begin
			if (!configured_ff)
			begin
				// first write may land anywhere in the reset window
				svc_ok = (wr_fields.key == `SVC_KEY);
				svc_bad = ~svc_ok;
			end
			else if (wr_fields != {cfg_ff.sel, `SVC_KEY, cfg_ff.cm_en})
				svc_bad = 1'b1;
			else if (wd_cnt_ff < `LOWER_TC)
				svc_bad = 1'b1;
			else
				svc_ok = 1'b1;
		end
	end

	assign wd_timeout = (wd_cnt_ff >= upper_tc) & (fstate_ff == wdog_pkg::F_IDLE);
	assign wd_trig = svc_bad | wd_timeout;

	// ************************************************************
	// stored configuration, captured once
	// ************************************************************
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cfg_ff.sel <= `SVC_SEL_RST;
			cfg_ff.key <= `SVC_KEY;
			cfg_ff.cm_en <= `SVC_CM_RST;
			configured_ff <= 1'b0;
		end
		else if (svc_ok & ~configured_ff)
		begin
			cfg_ff.sel <= wr_fields.sel;
			cfg_ff.cm_en <= wr_fields.cm_en;
			configured_ff <= 1'b1;
		end
	end

	// ************************************************************
	// window counter in instruction cycles
	// ************************************************************
	assign win_restart = svc_ok
		| idle_exit
		| (halt_exit & ~(ctrl_ff[`CTRL_RC_BIT] & ~ctrl_ff[`CTRL_DLY_BIT]))
		| (fstate_ff == wdog_pkg::F_WAIT_HIGH && fault_out_n_i && wd_err_ff);

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			wd_cnt_ff <= 17'h00000;
		else if (win_restart)
			wd_cnt_ff <= 17'h00000;
		else if (tc_en && !halt_mode && !idle_mode && fstate_ff == wdog_pkg::F_IDLE && !wd_timeout)
			wd_cnt_ff <= wd_cnt_ff + 17'h00001;
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			wd_err_ff <= 1'b0;
		else if (wd_trig)
			wd_err_ff <= 1'b1;
		else if (fstate_ff == wdog_pkg::F_WAIT_HIGH && fault_out_n_i)
			wd_err_ff <= 1'b0;
	end

	// ************************************************************
	// clock monitor: core cycles since last instruction cycle
	// ************************************************************
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			cm_cnt_ff <= 20'h00000;
		else if (tc_en)
			cm_cnt_ff <= 20'h00000;
		else if (cm_cnt_ff < CM_LIMIT_CYC[19:0])
			cm_cnt_ff <= cm_cnt_ff + 20'h00001;
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			cm_slow_ff <= 1'b0;
		else
			cm_slow_ff <= cfg_ff.cm_en & (cm_cnt_ff >= CM_LIMIT_CYC[19:0]);
	end

	assign cm_active = cm_slow_ff;

	// ************************************************************
	// fault pin sequencer
	// ************************************************************
	always_comb
	begin
		nxt_fstate = fstate_ff;
		unique case (fstate_ff)
			wdog_pkg::F_IDLE:
				if (wd_trig | cm_active)
					nxt_fstate = wdog_pkg::F_DRIVE;
			wdog_pkg::F_DRIVE:
				if (!fault_out_n_i)
					nxt_fstate = wdog_pkg::F_HOLD;
			wdog_pkg::F_HOLD:
				if (!cm_active && hold_ff == `HOLD_TC)
					nxt_fstate = wdog_pkg::F_WAIT_HIGH;
			wdog_pkg::F_WAIT_HIGH:
				if (cm_active)
					nxt_fstate = wdog_pkg::F_DRIVE;
				else if (fault_out_n_i)
					nxt_fstate = wdog_pkg::F_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			fstate_ff <= wdog_pkg::F_IDLE;
		else
			fstate_ff <= nxt_fstate;
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			hold_ff <= 5'h00;
		else if (fstate_ff != wdog_pkg::F_HOLD || cm_active)
			hold_ff <= 5'h00;
		else if (tc_en && hold_ff != `HOLD_TC)
			hold_ff <= hold_ff + 5'h01;
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			fault_out_n_oe <= 1'b0;
		else
			fault_out_n_oe <= (nxt_fstate == wdog_pkg::F_DRIVE) | (nxt_fstate == wdog_pkg::F_HOLD);
	end

	// driven level is only ever low
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			fault_out_n_o <= 1'b0;
		else
			fault_out_n_o <= 1'b0;
	end

	// ************************************************************
	// idle interval timer, free of reset, and its flag, cleared by reset
	// ************************************************************
	always_ff @(posedge core_clk)
	begin
		if (tc_en)
			idle_cnt_ff <= idle_cnt_ff + 16'h0001;
	end

	always_ff @(posedge core_clk)
	begin
		idle_bit_d_ff <= idle_cnt_ff[`IDLE_FLAG_BIT];
	end

	assign idle_flag_set = idle_bit_d_ff ^ idle_cnt_ff[`IDLE_FLAG_BIT];
	assign idle_flag_clr = wr_stat & writedata[`STAT_IDLE_FLAG_BIT];

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			idle_flag_ff <= 1'b0;
		else if (idle_flag_set)
			idle_flag_ff <= 1'b1;
		else if (idle_flag_clr)
			idle_flag_ff <= 1'b0;
	end

endmodule : windowed_watchdog_clock_monitor

// *** wdog_checker_assertions.sv ***
// assertion checker for the watchdog ports
`timescale 1ns/1ns
module wdog_checker #(
	parameter int CM_LIMIT_CYC = 50000
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire logic oscillator_input_pin,
	input wire logic fault_out_n_i,
	input wire logic fault_out_n_o,
	input wire logic fault_out_n_oe
);
	// ************************************************************
	// oscillator edges counted while the pin is held low
	// ************************************************************
	logic osc_q_ff;
	int hold_edges_ff;
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			osc_q_ff <= 1'b0;
			hold_edges_ff <= 0;
		end
		else
		begin
			osc_q_ff <= oscillator_input_pin;
			if (!fault_out_n_oe)
				hold_edges_ff <= 0;
			else if (oscillator_input_pin && !osc_q_ff && !fault_out_n_i)
				hold_edges_ff <= hold_edges_ff + 1;
		end
	end
	// ************************************************************
	// properties
	// ************************************************************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	AST_NEVER_DRIVE_HIGH: assert property (fault_out_n_o == 1'b0)
		else $error("fault pin driven high");
	AST_QUIET_IN_RESET: assert property (disable iff (1'b0) !rst_b |-> !fault_out_n_oe)
		else $error("fault pin driven in reset");
	AST_KEY_READS_ZERO: assert property (read && !waitrequest && address == 4'h0 |-> readdata[5:1] == 5'h00)
		else $error("key bits visible on read");
	AST_HOLD_UNTIL_LOW: assert property (fault_out_n_oe && fault_out_n_i |=> fault_out_n_oe)
		else $error("fault released before pin low");
	AST_HOLD_16_TC: assert property ($fell(fault_out_n_oe) |-> hold_edges_ff >= 160)
		else $error("fault hold shorter than 16 cycles");
	AST_RELEASE_AFTER_LOW: assert property ($fell(fault_out_n_oe) |-> $past(fault_out_n_i) == 1'b0)
		else $error("fault released while pin high");
	AST_BAD_KEY_FAULT: assert property (write && !waitrequest && address == 4'h0 && byteenable[0]
		&& writedata[5:1] != 5'h0c && !fault_out_n_oe && fault_out_n_i |-> ##[1:2] fault_out_n_oe)
		else $error("bad key without fault");
	AST_BUS_ANSWER: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
		else $error("bus answer not one cycle");
endmodule : wdog_checker

bind windowed_watchdog_clock_monitor wdog_checker #(.CM_LIMIT_CYC(CM_LIMIT_CYC)) u_wdog_checker (.core_clk,
	.rst_b, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .oscillator_input_pin,
	.fault_out_n_i, .fault_out_n_o, .fault_out_n_oe);

// *** fault_pin_pullup.sv ***
// supervisory side of the fault pin: pull-up wire that settles one cycle late
`timescale 1ns/1ns
module fault_pin_pullup (
	input wire logic core_clk,
	input wire logic fault_out_n_o,
	input wire logic fault_out_n_oe,
	output logic pin_level
);
	logic level_ff = 1'b1;
	// released pin rises to the pull-up level
	always @(posedge core_clk)
		level_ff <= fault_out_n_oe ? fault_out_n_o : 1'b1;
	assign pin_level = level_ff;
endmodule : fault_pin_pullup

// *** windowed_watchdog_clock_monitor_test.sv ***
// self-checking testbench of the watchdog and clock monitor
`timescale 1ns/1ns
module windowed_watchdog_clock_monitor_test;
	localparam int TC_CYC = 20;
	logic core_clk = 1'b0;
	logic rst_b;
	int osc_edges = 0;
	logic halt_model = 1'b0;
	logic [3:0] address = 4'h0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'hf;
	logic [31:0] readdata;
	logic waitrequest;
	logic oscillator_input_pin = 1'b0;
	logic osc_run = 1'b1;
	logic fault_out_n_i;
	logic fault_out_n_o;
	logic fault_out_n_oe;
	logic [31:0] rd;
	int mismatches = 0;
	int check_count = 0;
	int exp_sel = 3;
	int exp_cm = 1;
	windowed_watchdog_clock_monitor #(.CM_LIMIT_CYC(200)) u_windowed_watchdog_clock_monitor (.core_clk, .rst_b,
		.address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .oscillator_input_pin,
		.fault_out_n_i, .fault_out_n_o, .fault_out_n_oe);
	fault_pin_pullup u_fault_pin_pullup (.core_clk, .fault_out_n_o, .fault_out_n_oe, .pin_level(fault_out_n_i));
	initial
		forever #10 core_clk = ~core_clk;
	// reference count of oscillator rising edges that reach the divider
	always @(posedge core_clk)
		if (osc_run)
		begin
			oscillator_input_pin <= ~oscillator_input_pin;
			if (!oscillator_input_pin && !halt_model)
				osc_edges <= osc_edges + 1;
		end
	// ************************************************************
	// tasks
	// ************************************************************
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : check_word
	task automatic stuck(input string name);
		mismatches++;
		$display("MISMATCH %s expected done seen timeout", name);
		end_of_test();
	endtask : stuck
	task automatic bus(input logic is_wr, input logic [3:0] adr, input logic [7:0] data, output logic [31:0] got);
		int n;
		@(posedge core_clk);
		address <= adr;
		writedata <= ($urandom() & 32'hffffff00) | {24'h0, data};
		read <= !is_wr;
		write <= is_wr;
		for (n = 0; n < 50; n++)
		begin
			@(posedge core_clk);
			if (waitrequest === 1'b0)
				break;
		end
		got = readdata;
		if (is_wr && adr == 4'h4)
			halt_model = data[0];
		read <= 1'b0;
		write <= 1'b0;
		if (n == 50)
			stuck("bus");
	endtask : bus
	task automatic fault_cycle(input string name, input logic exp, input logic unhalt);
		int n;
		logic seen;
		seen = 1'b0;
		for (n = 0; n < 600 && !seen; n++)
		begin
			@(posedge core_clk);
			seen = (fault_out_n_oe === 1'b1);
		end
		check_word(name, {31'h0, exp}, {31'h0, seen});
		osc_run <= 1'b1;
		if (unhalt)
			bus(1'b1, 4'h4, 8'h00, rd);
		for (n = 0; n < 3000 && fault_out_n_oe !== 1'b0; n++)
			@(posedge core_clk);
		if (n == 3000)
			stuck(name);
		repeat (4) @(posedge core_clk);
	endtask : fault_cycle
	task automatic check_svc();
		bus(1'b0, 4'h0, 8'h00, rd);
		check_word("svc", {24'h0, exp_sel[1:0], 5'h00, exp_cm[0]}, rd);
	endtask : check_svc
	task automatic check_stat(input logic [31:0] exp);
		bus(1'b0, 4'h8, 8'h00, rd);
		check_word("status", exp, rd);
	endtask : check_stat
	// ************************************************************
	// sequence
	// ************************************************************
	initial
	begin
		rst_b <= 1'b0;
		void'($urandom(32'he244982f));
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b1;
		check_svc();
		check_stat(32'h00000010);
		bus(1'b0, 4'hc, 8'h00, rd);
		check_word("unmapped", 32'h0, rd);
		bus(1'b1, 4'h0, 8'h19, rd);
		exp_sel = 0;
		fault_cycle("first service", 1'b0, 1'b0);
		check_svc();
		bus(1'b1, 4'h0, 8'h19, rd);
		fault_cycle("early service", 1'b1, 1'b0);
		repeat (2050 * TC_CYC) @(posedge core_clk);
		bus(1'b1, 4'h0, 8'h18, rd);
		fault_cycle("monitor bit mismatch", 1'b1, 1'b0);
		check_svc();
		repeat (2050 * TC_CYC) @(posedge core_clk);
		bus(1'b1, 4'h0, 8'h19, rd);
		fault_cycle("late service", 1'b0, 1'b0);
		bus(1'b1, 4'h0, 8'h19, rd);
		fault_cycle("double service", 1'b1, 1'b0);
		osc_run <= 1'b0;
		fault_cycle("slow clock", 1'b1, 1'b0);
		bus(1'b1, 4'h0, {2'b00, 5'h0c ^ 5'(1 + $urandom_range(30)), 1'b1}, rd);
		fault_cycle("bad key", 1'b1, 1'b0);
		bus(1'b1, 4'h4, 8'h01, rd);
		fault_cycle("halt", 1'b1, 1'b1);
		check_stat({27'h0, 2'h3, 2'h0, 1'((osc_edges / 10) >= 4096)});
		bus(1'b1, 4'h8, 8'h01, rd);
		check_stat(32'h00000018);
		end_of_test();
	end
endmodule : windowed_watchdog_clock_monitor_test
